// >>> logic/psm_power_manager.v
// Behaviour
// RULE1: Low reset pin resets device, peripherals default, core restarts at address zero.
// RULE2: Other party holds wake pin high, then low at least 100 us, to exit.
// RULE3: Peripheral registers accessed only as aligned full 32-bit words.
// RULE4: Peripheral region spans 512 kB, each peripheral in a 16 kB slot.
// RULE5: System clock divided from 8 MHz, rates 8 MHz down to 62.5 kHz.
// RULE6: Divider defaults to 500 kHz after any reset.
// RULE7: Timer oscillator 32.768 kHz clocks power manager, cannot be disabled.
// RULE8: Gate register enables clock per peripheral; temperature sensor clock fixed.
// RULE9: Device reset from reset pin, watchdog or software request.
// RULE10: Battery switch stays open until reset pin rising edge or field power.
// RULE11: Battery used above 1.72 V; else field supply if higher.
// RULE12: Battery dropout or override switches to field at once, both directions.
// RULE13: Software can disable auto switch, comparator off, battery forced.
// RULE14: Without field power, manager can open battery switch, device off.
// RULE15: Brownout enabled raises interrupt when always-on voltage below 1.8 V.
// RULE16: Active 0/0 regs on; deep power-down 1/0 off; sleep 0/1 on.
// RULE17: Sequence: core regulator, analog regulator and flash, reset release, boot on flash.
// RULE18: Start-up from trigger to boot takes about 2.5 ms; code steps through three 21-cycle phases, about 2 ms.
// RULE19: Deep-sleep wakes on reset, timer, watchdog, wake pin, field, start logic.
// RULE20: Deep power-down wakes only on reset, timer, enabled wake pin, field.
// RULE21: Five always-on retention registers keep contents in deep power-down.
// RULE22: Power control picks sleep or deep power-down, flags, overrides; analog power-down.
// RULE23: Reset pin, wake pin and field detect synchronised before use.
// RULE24: Retention registers cleared only by always-on power-on reset.
`timescale 1ns/1ps
`include "psm_consts.vh"
module psm_power_manager (
    // Always-on timer clock and power-on reset
    input wire clk,
    input wire rst_b,
    // Pins and analog detectors
    input wire external_reset_pin,
    input wire wake_pin,
    input wire field_detect,
    input wire bat_above_thr,
    input wire field_above_bat,
    input wire alon_below_thr,
    input wire sysosc_stable,
    input wire flash_ready,
    // Core side events
    input wire wdt_reset,
    input wire wdt_irq,
    input wire sw_reset,
    input wire rtc_preset,
    input wire start_logic_irq,
    input wire core_sleep_req,
    input wire bat_off_req,
    // Control bits
    input wire [1:0] pd_mode_sel,
    input wire wake_pin_en,
    input wire field_wake_en,
    input wire brownout_en,
    input wire auto_switch_dis,
    input wire bat_override_off,
    input wire [`PSM_DIV_W-1:0] div_sel,
    input wire div_sel_we,
    input wire [`PSM_GATE_W-1:0] gate_val,
    input wire gate_we,
    input wire [`PSM_APD_W-1:0] apd_val,
    input wire apd_we,
    input wire [2:0] gp_idx,
    input wire [31:0] gp_wdata,
    input wire gp_we,
    input wire [31:0] bus_addr,
    input wire [2:0] bus_size,
    // Power switch and regulator controls
    output reg battery_power_switch,
    output reg field_power_switch,
    output reg core_regulator,
    output reg analog_regulator,
    output reg flash_en,
    output reg comparator_en,
    // Resets and boot
    output reg system_rst_b,
    output reg boot_go,
    output reg [31:0] boot_addr,
    // Clocks
    output reg [`PSM_DIV_W-1:0] sys_div_r,
    output reg [`PSM_GATE_W-1:0] clk_gate_r,
    output reg tsens_clk_en,
    output reg [`PSM_APD_W-1:0] apd_r,
    // Status
    output reg deep_powerdown_flag,
    output reg sleep_flag,
    output reg brownout_irq,
    output reg [31:0] gp_rdata,
    output wire bus_err,
    output wire [`PSM_SLOT_IDX_W-1:0] bus_slot
);

localparam [`PSM_ST_W-1:0] ST_OFF = 3'h0;
localparam [`PSM_ST_W-1:0] ST_CORE = 3'h1;
localparam [`PSM_ST_W-1:0] ST_ANA = 3'h2;
localparam [`PSM_ST_W-1:0] ST_BOOT = 3'h3;
localparam [`PSM_ST_W-1:0] ST_ACT = 3'h4;
localparam [`PSM_ST_W-1:0] ST_SLEEP = 3'h5;
localparam [`PSM_ST_W-1:0] ST_DPD = 3'h6;
localparam integer STEP_I = `PSM_STEP_CYC;
localparam integer WAKE_I = `PSM_WAKE_CYC;
localparam [11:0] STEP_CYC = STEP_I[11:0];
localparam [11:0] WAKE_CYC = WAKE_I[11:0];

// Word access check and slot decode
function word_ok;
    input [31:0] a;
    input [2:0] s;
    begin
        word_ok = (a[1:0] == 2'h0) && (s == 3'h2) && (a < `PSM_APB_SPAN);
    end
endfunction

// Saturating step for the phase counters
function [11:0] sat_inc;
    input [11:0] v;
    begin
        sat_inc = (v == 12'hfff) ? v : v + 12'h001;
    end
endfunction

// Analog domain and flash powered in this state
function ana_on;
    input [`PSM_ST_W-1:0] s;
    begin
        ana_on = (s >= ST_ANA) && (s != ST_DPD);
    end
endfunction

assign bus_err = ~word_ok(bus_addr, bus_size); // RULE3
assign bus_slot = bus_addr[`PSM_SLOT_BITS+`PSM_SLOT_IDX_W-1:`PSM_SLOT_BITS]; // RULE4

// Reset release
reg rs1_r, rs2_r;
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        rs1_r <= 1'b0;
        rs2_r <= 1'b0;
    end else begin
        rs1_r <= 1'b1;
        rs2_r <= rs1_r;
    end
end
wire rst_n = rs2_r; // RULE7

// Input synchronisers
reg [2:0] s1_r, s2_r;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        s1_r <= 3'h1;
        s2_r <= 3'h1;
    end else begin
        s1_r <= {field_detect, wake_pin, external_reset_pin}; // RULE23
        s2_r <= s1_r;
    end
end
wire rstpin_s = s2_r[0];
wire wake_s = s2_r[1];
wire field_s = s2_r[2];

reg rstpin_d_r;
reg armed_r;
reg [`PSM_ST_W-1:0] st_r, st_nxt;
reg [11:0] cnt_r;
reg [11:0] wcnt_r;
reg wake_hi_r;

wire trig = (rstpin_s & ~rstpin_d_r) | field_s;
wire dev_rst = ~rstpin_s | wdt_reset | sw_reset; // RULE9
wire wake_ok = wake_pin_en & wake_hi_r & (wcnt_r >= WAKE_CYC); // RULE2
wire ds_wake = ~rstpin_s | rtc_preset | wdt_irq | wdt_reset | wake_s == 1'b0
    | (field_wake_en & field_s) | start_logic_irq; // RULE19
wire dpd_wake = ~rstpin_s | rtc_preset | wake_ok | (field_wake_en & field_s); // RULE20

// Wake pin low-time counter
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        wcnt_r <= 12'h000;
        wake_hi_r <= 1'b0;
    end else begin
        if (st_r != ST_DPD)
            wake_hi_r <= wake_s;
        if (wake_s)
            wcnt_r <= 12'h000;
        else
            wcnt_r <= sat_inc(wcnt_r);
    end
end

// Power state machine
always @* begin
    st_nxt = st_r;
    case (st_r)
        ST_OFF: if (armed_r) st_nxt = ST_CORE; // RULE17
        ST_CORE: if (cnt_r >= STEP_CYC) st_nxt = ST_ANA;
        ST_ANA: if (cnt_r >= STEP_CYC && sysosc_stable) st_nxt = ST_BOOT;
        ST_BOOT: if (cnt_r >= STEP_CYC && flash_ready) st_nxt = ST_ACT; // RULE18
        ST_ACT: begin
            if (bat_off_req && !field_s)
                st_nxt = ST_OFF; // RULE14
            else if (core_sleep_req)
                st_nxt = (pd_mode_sel == `PSM_MODE_DPD) ? ST_DPD : ST_SLEEP; // RULE22
        end
        ST_SLEEP: if (ds_wake) st_nxt = ST_ACT;
        ST_DPD: if (dpd_wake) st_nxt = ST_CORE;
        default: st_nxt = ST_OFF;
    endcase
    if (dev_rst && st_r >= ST_BOOT)
        st_nxt = ST_BOOT; // RULE1
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        st_r <= ST_OFF;
        cnt_r <= 12'h000;
        rstpin_d_r <= 1'b1;
        armed_r <= 1'b0;
    end else begin
        st_r <= st_nxt;
        if (st_nxt != st_r || dev_rst)
            cnt_r <= 12'h000;
        else
            cnt_r <= sat_inc(cnt_r);
        rstpin_d_r <= rstpin_s;
        if (trig)
            armed_r <= 1'b1; // RULE10
        else if (st_nxt == ST_OFF && st_r == ST_ACT)
            armed_r <= 1'b0;
    end
end

// Outputs and control registers
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        battery_power_switch <= 1'b0;
        field_power_switch <= 1'b0;
        core_regulator <= 1'b0;
        analog_regulator <= 1'b0;
        flash_en <= 1'b0;
        comparator_en <= 1'b1;
        system_rst_b <= 1'b0;
        boot_go <= 1'b0;
        boot_addr <= 32'h0000_0000;
        sys_div_r <= `PSM_DIV_RST;
        clk_gate_r <= `PSM_GATE_RST;
        tsens_clk_en <= 1'b1;
        apd_r <= `PSM_APD_RST;
        deep_powerdown_flag <= 1'b0;
        sleep_flag <= 1'b0;
        brownout_irq <= 1'b0;
    end else begin
        comparator_en <= ~auto_switch_dis; // RULE13
        if (!armed_r) begin
            battery_power_switch <= 1'b0;
            field_power_switch <= 1'b0;
        end else if (auto_switch_dis) begin
            battery_power_switch <= 1'b1;
            field_power_switch <= 1'b0;
        end else if (bat_above_thr && !bat_override_off) begin
            battery_power_switch <= 1'b1; // RULE11
            field_power_switch <= 1'b0;
        end else begin
            battery_power_switch <= 1'b0; // RULE12
            field_power_switch <= field_s & (field_above_bat | bat_override_off);
        end
        core_regulator <= (st_nxt != ST_OFF) && (st_nxt != ST_DPD); // RULE16
        analog_regulator <= ana_on(st_nxt);
        flash_en <= ana_on(st_nxt);
        deep_powerdown_flag <= (st_nxt == ST_DPD);
        sleep_flag <= (st_nxt == ST_SLEEP);
        system_rst_b <= (st_nxt >= ST_BOOT) && (st_nxt != ST_DPD) && !dev_rst;
        boot_go <= (st_r == ST_BOOT) && (st_nxt == ST_ACT);
        boot_addr <= 32'h0000_0000; // RULE1
        if (st_nxt == ST_BOOT) begin
            sys_div_r <= `PSM_DIV_RST; // RULE6
            clk_gate_r <= `PSM_GATE_RST;
            apd_r <= `PSM_APD_RST;
        end else begin
            if (div_sel_we)
                sys_div_r <= div_sel; // RULE5
            if (gate_we)
                clk_gate_r <= gate_val; // RULE8
            if (apd_we)
                apd_r <= apd_val; // RULE22
        end
        tsens_clk_en <= 1'b1; // RULE8
        brownout_irq <= brownout_en & alon_below_thr; // RULE15
    end
end

// Retention registers, power-on reset only
reg [31:0] gp_mem [0:`PSM_GPREG_N-1];
integer i;
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        for (i = 0; i < `PSM_GPREG_N; i = i + 1)
            gp_mem[i] <= 32'h0000_0000; // RULE24
    end else if (gp_we && gp_idx < `PSM_GPREG_N) begin
        gp_mem[gp_idx] <= gp_wdata; // RULE21
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
        gp_rdata <= 32'h0000_0000;
    else
        gp_rdata <= (gp_idx < `PSM_GPREG_N) ? gp_mem[gp_idx] : 32'h0000_0000;
end

endmodule // psm_power_manager

// >>> shared/psm_consts.vh
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH
// Clock divider select codes (8 MHz / 2^sel)
`define PSM_DIV_W 3
`define PSM_DIV_RST 3'h4
// Power-up sequence timing
`define PSM_TIMER_OSC_HZ 32768
`define PSM_STARTUP_US 2500
`define PSM_STARTUP_CYC ((`PSM_STARTUP_US * `PSM_TIMER_OSC_HZ) / 1000000)
`define PSM_STEP_CYC (`PSM_STARTUP_CYC / 4)
`define PSM_WAKE_US 100
`define PSM_WAKE_CYC (((`PSM_WAKE_US * `PSM_TIMER_OSC_HZ) + 999999) / 1000000)
// Peripheral bus map
`define PSM_APB_SPAN 32'h0008_0000
`define PSM_SLOT_SIZE 32'h0000_4000
`define PSM_SLOT_BITS 14
`define PSM_SLOT_IDX_W 5
// Gate and retention widths
`define PSM_GATE_W 16
`define PSM_GATE_RST 16'hffff
`define PSM_APD_W 8
`define PSM_APD_RST 8'hff
`define PSM_GPREG_N 5
// Power control bits
`define PSM_MODE_SLEEP 2'h0
`define PSM_MODE_DPD 2'h1
`define PSM_ST_W 3
`endif

// >>> tb/psm_pm_sva.sv
`timescale 1ns/1ps
module psm_pm_sva (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Causes
    input wire brownout_en,
    input wire alon_below_thr,
    input wire sysosc_stable,
    input wire [31:0] bus_addr,
    input wire [2:0] bus_size,
    // Effects
    input wire core_regulator,
    input wire analog_regulator,
    input wire system_rst_b,
    input wire boot_go,
    input wire [31:0] boot_addr,
    input wire [2:0] sys_div_r,
    input wire deep_powerdown_flag,
    input wire sleep_flag,
    input wire brownout_irq,
    input wire bus_err
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence core_on;
        $rose(core_regulator) ##0 !analog_regulator;
    endsequence
    sequence rst_off;
        $rose(system_rst_b);
    endsequence
    boot_addr_a: assert property (boot_go |-> boot_addr == 32'h0)
        else $error("boot address not zero");
    boot_pulse_a: assert property (boot_go |=> !boot_go)
        else $error("boot pulse too long");
    core_first_a: assert property (core_on |=> !analog_regulator [*8])
        else $error("analog regulator too early");
    rst_release_a: assert property (rst_off |-> analog_regulator && $past(sysosc_stable))
        else $error("system reset released early");
    div_default_a: assert property (rst_off |-> sys_div_r == 3'h4)
        else $error("divider not at default");
    dpd_code_a: assert property (deep_powerdown_flag |-> !sleep_flag && !core_regulator
        && !analog_regulator)
        else $error("deep power-down coding wrong");
    sleep_code_a: assert property (sleep_flag |-> core_regulator && analog_regulator
        && !deep_powerdown_flag)
        else $error("sleep coding wrong");
    bus_size_a: assert property ((bus_size != 3'h2 || bus_addr[1:0] != 2'h0) |-> bus_err)
        else $error("partial access not refused");
    brownout_cause_a: assert property ($rose(brownout_irq) |->
        $past(brownout_en && alon_below_thr))
        else $error("brownout flag without cause");
endmodule // psm_pm_sva
bind psm_power_manager psm_pm_sva u_sva (.*);

// >>> tb/psm_core_model.sv
`timescale 1ns/1ps
module psm_core_model #(parameter LAT = 3) (
    // Clock
    input wire clk,
    // Supplies from the manager
    input wire core_regulator,
    input wire flash_en,
    // Readiness back
    output logic sysosc_stable = 1'b0,
    output logic flash_ready = 1'b0
);
    int osc_n = 0;
    int fl_n = 0;
    // Oscillator and flash settle LAT+1 cycles after power
    always @(posedge clk) begin
        osc_n <= core_regulator ? osc_n + 1 : 0;
        fl_n <= flash_en ? fl_n + 1 : 0;
        sysosc_stable <= core_regulator && osc_n >= LAT;
        flash_ready <= flash_en && fl_n >= LAT;
    end
endmodule // psm_core_model

// >>> tb/psm_power_manager_tb.sv
`timescale 1ns/1ps
module psm_power_manager_tb;
    logic clk = 0, rst_b = 0, external_reset_pin = 0, wake_pin = 0, field_detect = 0;
    logic bat_above_thr = 1, field_above_bat = 0, alon_below_thr = 0, wdt_reset = 0;
    logic wdt_irq = 0, sw_reset = 0, rtc_preset = 0, start_logic_irq = 0, core_sleep_req = 0;
    logic bat_off_req = 0, wake_pin_en = 1, field_wake_en = 0, brownout_en = 0;
    logic auto_switch_dis = 0;
    logic bat_override_off = 0, div_sel_we = 0, gate_we = 0, apd_we = 0, gp_we = 0;
    logic [1:0] pd_mode_sel = 0;
    logic [2:0] div_sel = 0, gp_idx = 0, bus_size = 0, sys_div_r;
    logic [15:0] gate_val = 0, clk_gate_r;
    logic [7:0] apd_val = 0, apd_r;
    logic [31:0] gp_wdata = 0, bus_addr = 0, boot_addr, gp_rdata, rv;
    logic sysosc_stable, flash_ready, battery_power_switch, field_power_switch, core_regulator;
    logic analog_regulator, flash_en, comparator_en, system_rst_b, boot_go, tsens_clk_en;
    logic deep_powerdown_flag, sleep_flag, brownout_irq, bus_err;
    logic [4:0] bus_slot;
    logic [31:0] gexp [5];
    int error_cnt = 0, cmp_count = 0, seed = 32'hc5bd, n;
    psm_power_manager DUT (.*);
    psm_core_model #(.LAT(3)) u_core (.clk(clk), .core_regulator(core_regulator),
        .flash_en(flash_en), .sysosc_stable(sysosc_stable), .flash_ready(flash_ready));
    initial forever #50 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task hold(input int c);
        repeat (c) @(negedge clk);
    endtask
    task wait_boot;
        n = 0;
        while (boot_go !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(n < 300, 1);
    endtask
    task rd_gp;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) gp_idx <= i;
            hold(2);
            chk(gp_rdata, gexp[i]);
        end
    endtask
    function logic exp_err(input logic [31:0] a, input logic [2:0] s);
        return s != 3'h2 || a[1:0] != 2'h0 || a >= 32'h80000;
    endfunction
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(100 * 3000);
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        hold(4);
        chk(sys_div_r, 4);
        chk({battery_power_switch, field_power_switch, system_rst_b}, 0);
        chk({clk_gate_r, apd_r, comparator_en, tsens_clk_en}, 26'h3ffffff);
        @(posedge clk) external_reset_pin <= 1;
        wait_boot;
        chk(n > 60 && n < 110, 1);
        chk({battery_power_switch, field_power_switch}, 2'h2);
        @(posedge clk) {bat_above_thr, field_detect, field_above_bat} <= 3'h3;
        hold(5);
        chk({battery_power_switch, field_power_switch}, 2'h1);
        @(posedge clk) bat_above_thr <= 1;
        hold(5);
        chk({battery_power_switch, field_power_switch}, 2'h2);
        @(posedge clk) bat_override_off <= 1;
        hold(3);
        chk({battery_power_switch, field_power_switch}, 2'h1);
        @(posedge clk) {bat_override_off, auto_switch_dis, bat_above_thr} <= 3'h2;
        hold(3);
        chk({comparator_en, battery_power_switch, field_power_switch}, 3'h2);
        @(posedge clk) {auto_switch_dis, field_detect, field_above_bat, bat_above_thr} <= 4'h1;
        for (int i = 0; i < 5; i++) begin
            rv = $random(seed);
            gexp[i] = rv;
            @(posedge clk) begin
                {div_sel, gate_val, apd_val, gp_idx, gp_wdata} <= {rv[2:0], rv[15:0], rv[23:16], 3'(i), rv};
                {div_sel_we, gate_we, apd_we, gp_we} <= 4'hf;
            end
            @(posedge clk) {div_sel_we, gate_we, apd_we, gp_we} <= 0;
            hold(1);
            chk({sys_div_r, clk_gate_r, apd_r}, {rv[2:0], rv[15:0], rv[23:16]});
        end
        for (int i = 0; i < 12; i++) begin
            rv = $random(seed) & (i[1] ? 32'hffffc : 32'hfffff);
            @(posedge clk) begin
                bus_addr <= i < 2 ? 32'h7fffc + 4 * i : rv;
                bus_size <= (i < 2 || i[0]) ? 3'h2 : rv[19:17];
            end
            hold(1);
            chk({bus_err, bus_slot}, {exp_err(bus_addr, bus_size), bus_addr[18:14]});
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) {div_sel, div_sel_we} <= 4'h1;
            @(posedge clk) begin
                {div_sel_we, external_reset_pin} <= {1'b0, k != 0};
                {wdt_reset, sw_reset} <= {k == 1, k == 2};
            end
            repeat (3) @(posedge clk);
            {external_reset_pin, wdt_reset, sw_reset} <= 3'h4;
            wait_boot;
            chk(sys_div_r, 4);
        end
        rd_gp;
        @(posedge clk) wake_pin <= 1;
        hold(3);
        @(posedge clk) core_sleep_req <= 1;
        hold(4);
        @(posedge clk) core_sleep_req <= 0;
        hold(1);
        chk({deep_powerdown_flag, sleep_flag, core_regulator, analog_regulator}, 4'h7);
        @(posedge clk) rtc_preset <= 1;
        @(posedge clk) rtc_preset <= 0;
        hold(4);
        chk(sleep_flag, 0);
        @(posedge clk) {pd_mode_sel, core_sleep_req} <= 3'h3;
        hold(4);
        @(posedge clk) {core_sleep_req, start_logic_irq} <= 2'h1;
        hold(6);
        chk({deep_powerdown_flag, sleep_flag, core_regulator, analog_regulator}, 4'h8);
        @(posedge clk) {start_logic_irq, wake_pin} <= 0;
        repeat (6) @(posedge clk);
        wake_pin <= 1;
        wait_boot;
        rd_gp;
        @(posedge clk) {wake_pin_en, field_wake_en, core_sleep_req} <= 3'h3;
        hold(4);
        @(posedge clk) {core_sleep_req, wake_pin} <= 0;
        repeat (6) @(posedge clk);
        wake_pin <= 1;
        hold(4);
        chk(deep_powerdown_flag, 1);
        @(posedge clk) field_detect <= 1;
        wait_boot;
        @(posedge clk) {brownout_en, alon_below_thr} <= 2'h3;
        hold(3);
        chk(brownout_irq, 1);
        @(posedge clk) bat_off_req <= 1;
        hold(4);
        chk({battery_power_switch, core_regulator}, 2'h3);
        @(posedge clk) field_detect <= 0;
        hold(5);
        chk({battery_power_switch, core_regulator}, 0);
        print_verdict;
    end
endmodule // psm_power_manager_tb
